// [core/nvc_host.sv]
// Notes on behaviour
// - reads drive chip enable low with write strobe and store line high
// - writes drive chip enable and write strobe low, store line high
// - software sequence reads 0000,1555,0AAA,1FFF,10F0 then 0F0F or 0F0E
// - write strobe stays high across all six sequence reads
// - host holds store line low at least 15 ns
// - any other access inside the sequence aborts it
// - each sequence read is framed by its own chip enable pulse
module nvc_host
  import nvc_pkg::*;
#(
  parameter int STORE_CYC = STORE_CYC_DEF
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic sw_valid_in,
  input wire logic sw_recall_in,
  input wire logic hw_store_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic busy_out,
  output logic [ADDR_W-1:0] address_lines_out,
  output logic chip_enable_n_out,
  output logic write_strobe_n_out,
  output logic output_gate_n_out,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic hw_store_busy_n_in,
  output logic hw_store_busy_n_out,
  output logic hw_store_busy_n_oe_out
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  nvc_state_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic wr_q, wr_d, ce_n_q, ce_n_d, rv_q, rv_d;
  logic sw_q, sw_d, rcl_q, rcl_d;
  logic [2:0] step_q, step_d;
  logic tload;
  logic [19:0] tval;
  logic tdone;
  logic [31:0] long_q, long_d;

  nvc_timer u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_in(tload),
    .value_in(tval),
    .done_out(tdone)
  );

  // sequence address for the current step of a software cycle
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input logic rc);
    logic [ADDR_W-1:0] a;
    a = SEQ_A0;
    case (s)
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      3'h5: a = rc ? SEQ_RECALL : SEQ_STORE;
      default: a = SEQ_A0;
    endcase
    return a;
  endfunction : seq_addr

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  // the long store wait uses its own 32-bit counter so it may exceed the timer
  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    wr_d = wr_q;
    ce_n_d = ce_n_q;
    rv_d = 1'b0;
    sw_d = sw_q;
    rcl_d = rcl_q;
    step_d = step_q;
    long_d = long_q;
    tload = 1'b0;
    tval = ACC_CYC;
    case (st_q)
      NVC_IDLE:
      begin
        if (hw_store_in)
        begin
          st_d = NVC_HREQ;
          tload = 1'b1;
          tval = PULSE_CYC;
        end
        else if (sw_valid_in)
        begin
          sw_d = 1'b1;
          rcl_d = sw_recall_in;
          step_d = 3'h0;
          wr_d = 1'b0;
          addr_d = seq_addr(3'h0, sw_recall_in);
          ce_n_d = 1'b0;
          st_d = NVC_ACC;
          tload = 1'b1;
        end
        else if (req_valid_in)
        begin
          sw_d = 1'b0;
          wr_d = req_write_in;
          addr_d = req_addr_in;
          wdat_d = req_wdata_in;
          ce_n_d = 1'b0;
          st_d = NVC_ACC;
          tload = 1'b1;
        end
      end
      NVC_ACC:
      begin
        if (tdone)
        begin
          if (!wr_q)
          begin
            rdat_d = data_lines_in;
            rv_d = !sw_q;
          end
          ce_n_d = 1'b1;
          st_d = NVC_GAP;
        end
      end
      NVC_GAP:
      begin
        // no other access is slotted between sequence reads
        if (sw_q && step_q != 3'h5)
        begin
          step_d = step_q + 3'h1;
          addr_d = seq_addr(step_q + 3'h1, rcl_q);
          ce_n_d = 1'b0;
          st_d = NVC_ACC;
          tload = 1'b1;
        end
        else if (sw_q)
        begin
          sw_d = 1'b0;
          st_d = NVC_SWAIT;
          long_d = 32'(STORE_CYC);
        end
        else
        begin
          st_d = NVC_IDLE;
        end
      end
      NVC_HREQ:
      begin
        // holds request for the pulse only; the busy, drain and store times are waited out next
        if (tdone)
        begin
          st_d = NVC_HWAIT;
          long_d = 32'(STORE_CYC) + 32'(DRAIN_CYC) + 32'(BUSY_CYC);
        end
      end
      NVC_HWAIT:
      begin
        if (long_q != 32'h00000000)
        begin
          long_d = long_q - 32'h00000001;
        end
        else if (hw_store_busy_n_in)
        begin
          st_d = NVC_RECOV;
          tload = 1'b1;
          tval = RECOV_CYC;
        end
      end
      NVC_RECOV:
      begin
        if (tdone)
        begin
          st_d = NVC_IDLE;
        end
      end
      NVC_SWAIT:
      begin
        if (long_q != 32'h00000000)
        begin
          long_d = long_q - 32'h00000001;
        end
        else
        begin
          st_d = NVC_IDLE;
        end
      end
      default: st_d = NVC_IDLE;
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      st_q <= NVC_IDLE;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      wr_q <= 1'b0;
      ce_n_q <= 1'b1;
      rv_q <= 1'b0;
      sw_q <= 1'b0;
      rcl_q <= 1'b0;
      step_q <= 3'h0;
      long_q <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      wr_q <= wr_d;
      ce_n_q <= ce_n_d;
      rv_q <= rv_d;
      sw_q <= sw_d;
      rcl_q <= rcl_d;
      step_q <= step_d;
      long_q <= long_d;
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  // strobe follows chip enable on writes and gate on reads; store line always high during access
  assign address_lines_out = addr_q;
  assign chip_enable_n_out = ce_n_q;
  assign write_strobe_n_out = !(wr_q && !ce_n_q);
  assign output_gate_n_out = wr_q || ce_n_q;
  assign data_lines_out = wdat_q;
  assign data_lines_oe_out = wr_q && !ce_n_q;
  assign hw_store_busy_n_out = 1'b0;
  assign hw_store_busy_n_oe_out = (st_q == NVC_HREQ);
  assign req_ready_out = (st_q == NVC_IDLE) && !hw_store_in;
  assign rsp_valid_out = rv_q;
  assign rsp_rdata_out = rdat_q;
  assign busy_out = (st_q != NVC_IDLE);

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_read_lines: assert property (@(posedge clk_in) disable iff (reset_in)
    (!chip_enable_n_out && !wr_q) |-> (write_strobe_n_out && !hw_store_busy_n_oe_out))
    else $error("read without high strobe");
  a_write_lines: assert property (@(posedge clk_in) disable iff (reset_in)
    !write_strobe_n_out |-> (!chip_enable_n_out && !hw_store_busy_n_oe_out && data_lines_oe_out))
    else $error("write framing wrong");
  a_seq_order: assert property (@(posedge clk_in) disable iff (reset_in)
    (sw_q && !chip_enable_n_out && step_q == 3'h1) |-> address_lines_out == SEQ_A1)
    else $error("sequence address wrong");
  a_seq_strobe: assert property (@(posedge clk_in) disable iff (reset_in)
    sw_q |-> write_strobe_n_out)
    else $error("strobe low in sequence");
  a_seq_final: assert property (@(posedge clk_in) disable iff (reset_in)
    (sw_q && step_q == 3'h5 && !chip_enable_n_out) |->
    address_lines_out == (rcl_q ? SEQ_RECALL : SEQ_STORE))
    else $error("final address wrong");
  a_pulse_len: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(hw_store_busy_n_oe_out) |-> hw_store_busy_n_oe_out [*2])
    else $error("store pulse too short");
  a_ce_toggle: assert property (@(posedge clk_in) disable iff (reset_in)
    (sw_q && $fell(chip_enable_n_out)) |-> ##1 !chip_enable_n_out ##1 chip_enable_n_out)
    else $error("enable not toggling");
  a_no_access_hw: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_q == NVC_HWAIT || st_q == NVC_RECOV) |-> chip_enable_n_out)
    else $error("access during store");
  a_deselect: assert property (@(posedge clk_in) disable iff (reset_in)
    chip_enable_n_out |-> (!data_lines_oe_out && output_gate_n_out))
    else $error("driving while deselected");
  c_read: cover property (@(posedge clk_in) disable iff (reset_in) rv_q);
  c_sw_done: cover property (@(posedge clk_in) disable iff (reset_in) st_q == NVC_SWAIT);
  c_hw_done: cover property (@(posedge clk_in) disable iff (reset_in) st_q == NVC_RECOV);
endmodule : nvc_host

// [core/nvc_timer.sv]
// --------------------------------------------------------------------------
// loadable down counter
// --------------------------------------------------------------------------
module nvc_timer
  import nvc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [19:0] value_in,
  output logic done_out
);
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;

  // counts down to zero and holds there
  always_comb
  begin
    cnt_d = cnt_q;
    if (load_in)
    begin
      cnt_d = value_in;
    end
    else if (cnt_q != 20'h00000)
    begin
      cnt_d = cnt_q - 20'h00001;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cnt_q <= 20'h00000;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = (cnt_q == 20'h00000) && !load_in;
endmodule : nvc_timer

// [dv/nvc_dev_model.sv]
// --------------------------------------------------------------------------
// behavioural nonvolatile sram seen from its pins
// --------------------------------------------------------------------------
module nvc_dev_model
  import nvc_pkg::*;
#(
  parameter int STORE_NS = 1500
)
(
  input wire logic [ADDR_W-1:0] address_lines_in,
  input wire logic chip_enable_n_in,
  input wire logic write_strobe_n_in,
  input wire logic output_gate_n_in,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic hw_store_busy_n_in,
  output logic hw_store_busy_n_oe_out,
  output int store_count_out,
  output int recall_count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [12:0] SEQ_L [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [DATA_W-1:0] sram_q [0:8191];
  logic [DATA_W-1:0] nv_q [0:8191];
  logic dirty_q = 1'b0;
  logic inhibit_q = 1'b0;
  logic we_at_ce_q = 1'b0;
  int seq_q = 0;

  initial
  begin
    hw_store_busy_n_oe_out = 1'b0;
    store_count_out = 0;
    recall_count_out = 0;
  end

  // drive only for a selected read while no nonvolatile work runs
  assign data_lines_oe_out = !chip_enable_n_in && write_strobe_n_in && !output_gate_n_in && hw_store_busy_n_in
    && !inhibit_q && !we_at_ce_q;
  assign data_lines_out = sram_q[address_lines_in];

  // each chip-enable pulse is one access, judged 50 ns after the falling edge to dodge edge races
  always @(negedge chip_enable_n_in)
  begin
    we_at_ce_q = !write_strobe_n_in;
    #50;
    if (inhibit_q || !hw_store_busy_n_in)
      seq_q = 0;
    else if (!write_strobe_n_in)
    begin
      sram_q[address_lines_in] = data_lines_in;
      dirty_q = 1'b1;
      seq_q = 0;
    end
    else if (seq_q == 5 && (address_lines_in == SEQ_STORE || address_lines_in == SEQ_RECALL))
    begin
      // output gate plays no part here
      inhibit_q = 1'b1;
      if (address_lines_in == SEQ_STORE)
        nv_q = sram_q;
      else
        sram_q = nv_q;
      store_count_out += (address_lines_in == SEQ_STORE) ? 1 : 0;
      recall_count_out += (address_lines_in == SEQ_RECALL) ? 1 : 0;
      dirty_q = 1'b0;
      seq_q = 0;
      #STORE_NS;
      inhibit_q = 1'b0;
    end
    else
      seq_q = (seq_q < 5 && address_lines_in == SEQ_L[seq_q]) ? seq_q + 1 : int'(address_lines_in == SEQ_A0);
  end

  // hardware store: grab the line, drain, store only if dirty, hold off until released
  always @(negedge hw_store_busy_n_in)
  begin
    #50;
    hw_store_busy_n_oe_out = 1'b1;
    #950;
    inhibit_q = 1'b1;
    if (dirty_q)
    begin
      nv_q = sram_q;
      store_count_out++;
      dirty_q = 1'b0;
      #STORE_NS;
    end
    hw_store_busy_n_oe_out = 1'b0;
    wait (hw_store_busy_n_in === 1'b1);
    #500;
    inhibit_q = 1'b0;
  end
endmodule : nvc_dev_model

// [dv/tb_nvsram_mode_and_store_control.sv]
module tb_nvsram_mode_and_store_control
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic sw_valid_in = 1'b0;
  logic sw_recall_in = 1'b0;
  logic hw_store_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [DATA_W-1:0] req_wdata_in = '0;
  logic req_ready_out, rsp_valid_out, busy_out, chip_enable_n_out, write_strobe_n_out, output_gate_n_out;
  logic data_lines_oe_out, hw_store_busy_n_out, hw_store_busy_n_oe_out, dev_oe, dev_hsb_oe;
  logic [DATA_W-1:0] rsp_rdata_out, data_lines_out, dev_data, data_lines_in, last_q;
  logic [ADDR_W-1:0] address_lines_out;
  logic hw_store_busy_n_in;
  logic [DATA_W-1:0] shadow [0:8191];
  logic [ADDR_W-1:0] ad_q [0:23];
  int store_n, recall_n;
  int bad_count = 0;
  int compares = 0;
  int seed = 32357;

  always #50 clk_in = ~clk_in;

  // ---------------------------------------------------------------------
  // wires: store line pulled up, a released data bus shows inverted history
  // ---------------------------------------------------------------------
  assign hw_store_busy_n_in = !((hw_store_busy_n_oe_out && !hw_store_busy_n_out) || dev_hsb_oe);
  assign data_lines_in = data_lines_oe_out ? data_lines_out : dev_oe ? dev_data : ~last_q;
  always @(posedge clk_in) last_q <= data_lines_in;

  nvc_host #(.STORE_CYC(20)) dut_u (.clk_in, .reset_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .sw_valid_in, .sw_recall_in, .hw_store_in, .req_ready_out, .rsp_valid_out,
    .rsp_rdata_out, .busy_out, .address_lines_out, .chip_enable_n_out, .write_strobe_n_out,
    .output_gate_n_out, .data_lines_in, .data_lines_out, .data_lines_oe_out, .hw_store_busy_n_in,
    .hw_store_busy_n_out, .hw_store_busy_n_oe_out);

  nvc_dev_model #(.STORE_NS(1500)) dev_u (.address_lines_in(address_lines_out),
    .chip_enable_n_in(chip_enable_n_out), .write_strobe_n_in(write_strobe_n_out),
    .output_gate_n_in(output_gate_n_out), .data_lines_in(data_lines_in), .data_lines_out(dev_data),
    .data_lines_oe_out(dev_oe), .hw_store_busy_n_in(hw_store_busy_n_in),
    .hw_store_busy_n_oe_out(dev_hsb_oe), .store_count_out(store_n), .recall_count_out(recall_n));

  task automatic results();
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("mismatch at %0t ns: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  // the first look is a falling edge, so ready from before a take is never seen
  task automatic wait_ready(input int limit);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (req_ready_out !== 1'b1 && n < limit);
    // judged on ready itself, so a ready seen on the last look still counts
    if (req_ready_out !== 1'b1)
    begin
      check(32'(req_ready_out), 32'h1);
      results();
    end
  endtask : wait_ready

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    wait_ready(10);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    while (!wr && rsp_valid_out !== 1'b1 && n < 8)
    begin
      @(negedge clk_in);
      n++;
    end
    if (!wr)
      check(32'(rsp_valid_out), 32'h1);
    // a lost read answer ends the run through the closing report
    if (!wr && rsp_valid_out !== 1'b1)
      results();
    q = rsp_rdata_out;
  endtask : access

  // kind 0 soft store, 1 soft recall, 2 hardware store
  task automatic nv_request(input int kind);
    wait_ready(10);
    @(posedge clk_in);
    sw_valid_in <= (kind < 2);
    sw_recall_in <= (kind == 1);
    hw_store_in <= (kind == 2);
    @(posedge clk_in);
    sw_valid_in <= 1'b0;
    hw_store_in <= 1'b0;
    @(negedge clk_in);
    check(32'(busy_out), 32'h1);
    wait_ready(2000);
  endtask : nv_request

  // both sides driving the data bus at once is never allowed
  always @(negedge clk_in)
    if (!reset_in)
      check(32'(data_lines_oe_out & dev_oe), 32'h0);

  initial
  begin
    logic [DATA_W-1:0] got, v1, v2;
    logic [ADDR_W-1:0] a;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    // random writes with both address ends, read back in reverse order
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
      v1 = 8'($random(seed));
      ad_q[i] = a;
      shadow[a] = v1;
      access(1'b1, a, v1, got);
    end
    for (int i = 23; i >= 0; i--)
    begin
      access(1'b0, ad_q[i], 8'h00, got);
      check(32'(got), 32'(shadow[ad_q[i]]));
    end
    // soft store, overwrite, soft recall brings the stored byte back
    v1 = 8'($random(seed));
    v2 = ~v1;
    access(1'b1, 13'h0123, v1, got);
    nv_request(0);
    check(32'(store_n), 32'h1);
    access(1'b1, 13'h0123, v2, got);
    nv_request(1);
    check(32'(recall_n), 32'h1);
    access(1'b0, 13'h0123, 8'h00, got);
    check(32'(got), 32'(v1));
    // hardware store after a write, then again with nothing written
    access(1'b1, 13'h0456, v2, got);
    nv_request(2);
    check(32'(store_n), 32'h2);
    access(1'b0, 13'h0456, 8'h00, got);
    check(32'(got), 32'(v2));
    nv_request(2);
    check(32'(store_n), 32'h2);
    access(1'b1, 13'h0456, v1, got);
    nv_request(1);
    access(1'b0, 13'h0456, 8'h00, got);
    check(32'(got), 32'(v2));
    results();
  end
endmodule : tb_nvsram_mode_and_store_control

// [include/nvc_pkg.sv]
package nvc_pkg;
  // --------------------------------------------------------------------------
  // pin widths and sequence addresses
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0AAA;
  localparam logic [12:0] SEQ_A3 = 13'h1FFF;
  localparam logic [12:0] SEQ_A4 = 13'h10F0;
  localparam logic [12:0] SEQ_STORE = 13'h0F0F;
  localparam logic [12:0] SEQ_RECALL = 13'h0F0E;
  // --------------------------------------------------------------------------
  // timing, clock period 100 ns
  // --------------------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int STORE_REQUEST_PULSE_NS = 15;
  localparam int REQUEST_TO_BUSY_TIME_NS = 300;
  localparam int ACCESS_DRAIN_TIME_NS = 1000;
  localparam int STORE_DURATION_MS = 10;
  localparam int INHIBIT_RELEASE_TIME_NS = 700;
  localparam int ACCESS_NS = 100;
  // least times round up, longest round down; pulse, busy and access never below one
  localparam int PULSE_CYC_I = (STORE_REQUEST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC_I = REQUEST_TO_BUSY_TIME_NS / CLK_NS;
  localparam int DRAIN_CYC_I = (ACCESS_DRAIN_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC_I = (INHIBIT_RELEASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CYC_I = STORE_DURATION_MS * 1000000 / CLK_NS;
  localparam int ACC_CYC_I = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [19:0] PULSE_CYC = 20'(PULSE_CYC_I < 1 ? 1 : PULSE_CYC_I);
  localparam logic [19:0] BUSY_CYC = 20'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
  localparam logic [19:0] DRAIN_CYC = 20'(DRAIN_CYC_I);
  localparam logic [19:0] RECOV_CYC = 20'(RECOV_CYC_I);
  localparam int STORE_CYC_DEF = STORE_CYC_I;
  localparam logic [19:0] ACC_CYC = 20'(ACC_CYC_I < 1 ? 1 : ACC_CYC_I);
  // --------------------------------------------------------------------------
  // host states, gray along read/write path except gap back to idle
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    NVC_IDLE = 3'h0,
    NVC_ACC = 3'h1,
    NVC_GAP = 3'h3,
    NVC_HREQ = 3'h2,
    NVC_HWAIT = 3'h6,
    NVC_RECOV = 3'h7,
    NVC_SWAIT = 3'h5
  } nvc_state_t;
endpackage : nvc_pkg
